// ### core/lbcs_ctrl.v
/*
 * local bus control signalling plus reset-time strap capture on the shared pins.
 * assumes: the access request comes from core logic on mclk; primary_bus_reset,
 * the strap/pin inputs, ext_ready_recover and bus_grant_request are asynchronous
 * pins; mc_ready comes from the memory controller on mclk; a pad ring resolves
 * the three-signal pins and applies the weak pull-ups while strap_pullup_en is high.
 */
`timescale 1ns/10ps
`include "lbcs_defines.vh"

module lbcs_ctrl #(
  parameter BEATS_W = `LBCS_BEATS_W
) (
  input wire mclk,
  input wire rst,
  input wire primary_bus_reset,
  // access request from core logic
  input wire req_valid,
  input wire req_write,
  input wire req_data,
  input wire req_atomic,
  input wire req_lock_end,
  input wire [BEATS_W-1:0] req_beats,
  output wire req_ready,
  output wire xfer_done,
  // ready sources
  input wire use_internal_mc,
  input wire mc_ready,
  input wire ext_ready_recover,
  // software clears the core reset bit
  input wire core_reset_clear,
  // bus hand-over
  input wire bus_grant_request,
  output reg bus_grant_ack,
  // plain outputs
  output reg write_read_flag,
  output reg xfer_direction,
  output reg data_phase_enable_n,
  // shared pins, each input/output/enable, then the input-only region_size_retry_strap
  input wire data_code_flag_i,
  output wire data_code_flag_o,
  output wire data_code_flag_oe,
  input wire atomic_lock_i,
  output wire atomic_lock_o,
  output wire atomic_lock_oe,
  input wire local_ready_recover_i,
  output wire local_ready_recover_o,
  output wire local_ready_recover_oe,
  input wire region_size_retry_strap,
  // reset and initialization results
  output wire strap_pullup_en,
  output reg core_reset,
  output reg periph_pci_access_en,
  output reg init_start,
  output reg internal_selftest_en,
  output reg bus_confidence_en,
  output reg float_test_mode,
  output reg clocks_stop
);

  reg [1:0] state_ff;
  reg [1:0] nxt_state;
  reg [BEATS_W-1:0] beats_ff;
  reg [BEATS_W-1:0] nxt_beats;
  reg dcf_ff;
  reg lock_n_ff;
  reg lock_end_ff;
  reg lrdy_n_ff;
  // two-flop synchronisers for every asynchronous pin
  reg prst_s1_ff, prst_s2_ff, prst_d_ff;
  reg hold_s1_ff, hold_s2_ff;
  reg chs_s1_ff, chs_s2_ff;
  reg fts_s1_ff, fts_s2_ff;
  reg sts_s1_ff, sts_s2_ff;
  reg rgn_s1_ff, rgn_s2_ff;
  reg erdy_s1_ff, erdy_s2_ff;
  reg core_hold_strap_ff;
  reg float_strap_ff;
  reg selftest_strap_ff;
  reg region_strap_ff;
  reg core_held_ff;

  wire in_reset = prst_s2_ff;
  wire reset_release = prst_d_ff & ~prst_s2_ff;
  wire ready = use_internal_mc ? mc_ready : ~erdy_s2_ff;
  wire pins_drive = ~in_reset & ~float_test_mode & ~bus_grant_ack;

  always @(posedge mclk) begin
    if (rst) begin
      prst_s1_ff <= 1'h1;
      prst_s2_ff <= 1'h1;
      prst_d_ff <= 1'h1;
      hold_s1_ff <= 1'h0;
      hold_s2_ff <= 1'h0;
      chs_s1_ff <= `LBCS_STRAP_INACTIVE;
      chs_s2_ff <= `LBCS_STRAP_INACTIVE;
      fts_s1_ff <= `LBCS_STRAP_INACTIVE;
      fts_s2_ff <= `LBCS_STRAP_INACTIVE;
      sts_s1_ff <= `LBCS_STRAP_INACTIVE;
      sts_s2_ff <= `LBCS_STRAP_INACTIVE;
      rgn_s1_ff <= `LBCS_STRAP_INACTIVE;
      rgn_s2_ff <= `LBCS_STRAP_INACTIVE;
      erdy_s1_ff <= 1'h1;
      erdy_s2_ff <= 1'h1;
    end else begin
      prst_s1_ff <= primary_bus_reset;
      prst_s2_ff <= prst_s1_ff;
      prst_d_ff <= prst_s2_ff;
      hold_s1_ff <= bus_grant_request;
      hold_s2_ff <= hold_s1_ff;
      chs_s1_ff <= data_code_flag_i;
      chs_s2_ff <= chs_s1_ff;
      fts_s1_ff <= atomic_lock_i;
      fts_s2_ff <= fts_s1_ff;
      sts_s1_ff <= local_ready_recover_i;
      sts_s2_ff <= sts_s1_ff;
      rgn_s1_ff <= region_size_retry_strap;
      rgn_s2_ff <= rgn_s1_ff;
      erdy_s1_ff <= ext_ready_recover;
      erdy_s2_ff <= erdy_s1_ff;
    end
  end

  // straps follow the pins while reset is applied and freeze at release,
  // so the value kept is the one seen at the end of reset
  always @(posedge mclk) begin
    if (rst) begin
      core_hold_strap_ff <= `LBCS_STRAP_INACTIVE;
      float_strap_ff <= `LBCS_STRAP_INACTIVE;
      selftest_strap_ff <= `LBCS_STRAP_INACTIVE;
      region_strap_ff <= `LBCS_STRAP_INACTIVE;
    end else if (in_reset) begin
      core_hold_strap_ff <= chs_s2_ff;
      float_strap_ff <= fts_s2_ff;
      selftest_strap_ff <= sts_s2_ff;
      region_strap_ff <= rgn_s2_ff;
    end
  end

  assign strap_pullup_en = in_reset;

  always @(posedge mclk) begin
    if (rst) begin
      core_held_ff <= 1'h0;
      core_reset <= 1'h1;
      periph_pci_access_en <= 1'h0;
      init_start <= 1'h0;
      internal_selftest_en <= 1'h0;
      bus_confidence_en <= 1'h0;
      float_test_mode <= 1'h0;
      clocks_stop <= 1'h0;
    end else begin
      init_start <= 1'h0;
      if (in_reset) begin
        core_held_ff <= 1'h0;
        core_reset <= 1'h1;
        float_test_mode <= 1'h0;
        clocks_stop <= 1'h0;
      end else if (reset_release) begin
        core_held_ff <= ~core_hold_strap_ff;
        core_reset <= ~core_hold_strap_ff;
        init_start <= core_hold_strap_ff & float_strap_ff;
        internal_selftest_en <= selftest_strap_ff;
        bus_confidence_en <= 1'h1;
        float_test_mode <= ~float_strap_ff;
        clocks_stop <= ~float_strap_ff;
      end else if (core_held_ff & core_reset_clear) begin
        core_held_ff <= 1'h0;
        core_reset <= 1'h0;
        init_start <= ~float_test_mode;
      end
      periph_pci_access_en <= core_reset & ~in_reset & region_strap_ff;
    end
  end

  // sequencer: idle -> address -> data (waits while not ready) -> recovery
  always @* begin
    nxt_state = state_ff;
    nxt_beats = beats_ff;
    case (state_ff)
      `LBCS_ST_IDLE: begin
        if (req_valid & ~bus_grant_ack & ~core_reset & ~float_test_mode) begin
          nxt_state = `LBCS_ST_ADDR;
          nxt_beats = req_beats;
        end
      end
      `LBCS_ST_ADDR: begin
        nxt_state = `LBCS_ST_DATA;
      end
      `LBCS_ST_DATA: begin
        if (ready) begin
          if (beats_ff == {BEATS_W{1'b0}}) begin
            nxt_state = `LBCS_ST_RECOV;
          end else begin
            nxt_beats = beats_ff - {{(BEATS_W-1){1'b0}}, 1'b1};
          end
        end
      end
      `LBCS_ST_RECOV: begin
        nxt_state = `LBCS_ST_IDLE;
      end
      default: begin
        nxt_state = `LBCS_ST_IDLE;
      end
    endcase
  end

  wire start = (state_ff == `LBCS_ST_IDLE) & (nxt_state == `LBCS_ST_ADDR);
  wire last_xfer = (state_ff == `LBCS_ST_DATA) & ready & (beats_ff == {BEATS_W{1'b0}});

  assign req_ready = (state_ff == `LBCS_ST_IDLE) & ~bus_grant_ack & ~core_reset & ~float_test_mode;
  assign xfer_done = last_xfer;

  always @(posedge mclk) begin
    if (rst | in_reset) begin
      state_ff <= `LBCS_ST_IDLE;
      beats_ff <= {BEATS_W{1'b0}};
      write_read_flag <= `LBCS_RST_WR;
      dcf_ff <= `LBCS_RST_DCF;
      xfer_direction <= `LBCS_RST_DIR;
      data_phase_enable_n <= `LBCS_RST_DEN_N;
      lock_n_ff <= `LBCS_RST_LOCK_N;
      lock_end_ff <= 1'h0;
      bus_grant_ack <= `LBCS_RST_GRANT;
      lrdy_n_ff <= 1'h1;
    end else begin
      state_ff <= nxt_state;
      beats_ff <= nxt_beats;
      if (start) begin
        // flags change only as the address phase begins, data enable is off then
        write_read_flag <= req_write ? `LBCS_FLAG_WRITE : `LBCS_FLAG_READ;
        dcf_ff <= req_data ? `LBCS_FLAG_DATA : `LBCS_FLAG_CODE;
        xfer_direction <= req_write;
        lock_end_ff <= req_atomic & req_lock_end;
        if (req_atomic) begin
          lock_n_ff <= 1'h0;
        end
      end
      // asserted from the first data cycle through the cycle that ends the last
      data_phase_enable_n <= ~((nxt_state == `LBCS_ST_DATA));
      if (last_xfer & lock_end_ff) begin
        lock_n_ff <= 1'h1;
      end
      // hand over only between accesses and never inside a locked sequence
      if (bus_grant_ack) begin
        bus_grant_ack <= hold_s2_ff;
      end else if (hold_s2_ff & (state_ff == `LBCS_ST_IDLE) & lock_n_ff & ~req_valid) begin
        bus_grant_ack <= 1'h1;
      end
      lrdy_n_ff <= ~(mc_ready & (state_ff == `LBCS_ST_DATA));
    end
  end

  assign data_code_flag_o = dcf_ff;
  assign data_code_flag_oe = pins_drive;
  assign atomic_lock_o = lock_n_ff;
  assign atomic_lock_oe = pins_drive;
  assign local_ready_recover_o = lrdy_n_ff;
  assign local_ready_recover_oe = pins_drive & use_internal_mc;

endmodule // lbcs_ctrl

// ### core/lbcs_defines.vh
/*
 * constants for the local bus control and strap block: sequencer state
 * codes, flop reset values and the strap levels.
 * assumes it is included by its bare name from the design file.
 */
`ifndef LBCS_DEFINES_VH
`define LBCS_DEFINES_VH

`define LBCS_ST_IDLE 2'h0
`define LBCS_ST_ADDR 2'h1
`define LBCS_ST_DATA 2'h2
`define LBCS_ST_RECOV 2'h3

`define LBCS_FLAG_READ 1'h0
`define LBCS_FLAG_WRITE 1'h1
`define LBCS_FLAG_CODE 1'h0
`define LBCS_FLAG_DATA 1'h1

`define LBCS_RST_WR 1'h0
`define LBCS_RST_DIR 1'h0
`define LBCS_RST_DEN_N 1'h1
`define LBCS_RST_LOCK_N 1'h1
`define LBCS_RST_DCF 1'h1
`define LBCS_RST_GRANT 1'h0

`define LBCS_STRAP_INACTIVE 1'h1
`define LBCS_BEATS_W 2

`endif

// ### sim/lbcs_far_end.sv
/* far side of the local bus: ready source and an external master.
   assumes the bench changes slow and want_bus just after an edge. */
`timescale 1ns/10ps
module lbcs_far_end (
  input wire mclk,
  input wire data_phase_enable_n,
  input wire bus_grant_ack,
  input wire [1:0] slow,
  input wire want_bus,
  output wire mc_ready,
  output wire ext_ready_recover,
  output logic bus_grant_request
);
  logic [1:0] waited = 2'h0;
  assign mc_ready = !data_phase_enable_n && waited >= slow;
  // board resistor pulls the pin high outside data cycles
  assign ext_ready_recover = !mc_ready;
  initial bus_grant_request = 1'b0;
  always @(posedge mclk) begin
    waited <= (data_phase_enable_n || mc_ready) ? 2'h0 : waited + 2'h1;
    bus_grant_request <= want_bus || (bus_grant_request && !bus_grant_ack);
  end
endmodule // lbcs_far_end

// ### sim/lbcs_asserts.sv
/* checker for lbcs_ctrl: flag timing, data enable, lock, ready copy.
   assumes a bind into lbcs_ctrl, one clock mclk, sync rst. */
`timescale 1ns/10ps
module lbcs_checker (
  input wire mclk,
  input wire rst,
  input wire req_valid,
  input wire req_ready,
  input wire req_atomic,
  input wire xfer_done,
  input wire write_read_flag,
  input wire xfer_direction,
  input wire data_phase_enable_n,
  input wire data_code_flag_o,
  input wire atomic_lock_o,
  input wire bus_grant_ack,
  input wire use_internal_mc,
  input wire mc_ready,
  input wire local_ready_recover_o,
  input wire strap_pullup_en
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  dir_hold_a: assert property (!data_phase_enable_n |=> data_phase_enable_n || $stable(xfer_direction))
    else $error("direction moved");
  dir_match_a: assert property (!data_phase_enable_n |-> xfer_direction == write_read_flag)
    else $error("direction vs write flag");
  code_flag_a: assert property ($changed(data_code_flag_o) |-> $past(req_valid && req_ready) || $past(strap_pullup_en))
    else $error("code flag moved");
  den_start_a: assert property (req_valid && req_ready |=> ##1 !data_phase_enable_n)
    else $error("data enable late");
  no_grant_a: assert property (!atomic_lock_o |-> !bus_grant_ack)
    else $error("grant in lock");
  lock_set_a: assert property (req_valid && req_ready && req_atomic |=> !atomic_lock_o)
    else $error("lock missing");
  lock_free_a: assert property ($rose(atomic_lock_o) |-> $past(xfer_done) || $past(strap_pullup_en))
    else $error("lock freed early");
  rdy_copy_a: assert property (use_internal_mc && mc_ready && !data_phase_enable_n |=> !local_ready_recover_o)
    else $error("ready copy missing");
endmodule // lbcs_checker

// ### sim/lbcs_ctrl_bench.sv
/* self-checking bench for lbcs_ctrl with far-end model and checker.
   assumes the declared lbcs_ctrl ports and a 100 ns mclk. */
`timescale 1ns/10ps
module lbcs_ctrl_bench;
  logic mclk = 1'b0, rst = 1'b1, primary_bus_reset = 1'b1, req_valid = 1'b0, req_write = 1'b0, req_data = 1'b0;
  logic req_atomic = 1'b0, req_lock_end = 1'b0, use_internal_mc = 1'b1, core_reset_clear = 1'b0, want_bus = 1'b0;
  logic hold_s = 1'b1, float_s = 1'b1, test_s = 1'b1, region_size_retry_strap = 1'b1;
  logic [1:0] req_beats = 2'h0, slow = 2'h0;
  wire req_ready, xfer_done, bus_grant_ack, write_read_flag, xfer_direction, data_phase_enable_n, mc_ready;
  wire ext_ready_recover, bus_grant_request, data_code_flag_o, data_code_flag_oe, atomic_lock_o, atomic_lock_oe;
  wire local_ready_recover_o, local_ready_recover_oe, strap_pullup_en, core_reset, periph_pci_access_en;
  wire init_start, internal_selftest_en, bus_confidence_en, float_test_mode, clocks_stop;
  // an undriven pin shows its strap level
  wire data_code_flag_i = data_code_flag_oe ? data_code_flag_o : hold_s;
  wire atomic_lock_i = atomic_lock_oe ? atomic_lock_o : float_s;
  wire local_ready_recover_i = local_ready_recover_oe ? local_ready_recover_o : test_s;
  int n_errors = 0, checks_done = 0;
  logic [2:0] q[$];
  int n_init = 0;
  lbcs_ctrl dut_u (.*);
  lbcs_far_end far_u (.*);
  initial forever #50 mclk = ~mclk;
  // init_start is a one-cycle pulse, so count it away from the launching edge
  always @(negedge mclk)
    if (init_start === 1'b1) n_init++;
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic chk(input logic [5:0] got, exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: %h vs %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic boot(input logic h, f, t, r);
    int n0;
    n0 = n_init;
    {hold_s, float_s, test_s, region_size_retry_strap} = {h, f, t, r};
    primary_bus_reset = 1'b1;
    tick(5);
    chk(6'(strap_pullup_en), 6'h1);
    primary_bus_reset = 1'b0;
    tick(5);
    // flip the straps: captured values must not follow
    {hold_s, float_s, test_s, region_size_retry_strap} = {~h, ~f, ~t, ~r};
    tick(3);
    chk(6'({core_reset, periph_pci_access_en, float_test_mode, clocks_stop}), 6'({~h, ~h & r, ~f, ~f}));
    chk(6'({internal_selftest_en, bus_confidence_en}), 6'({t, 1'b1}));
    chk(6'(n_init - n0), 6'(h & f));
    if (!h) begin
      core_reset_clear = 1'b1;
      tick(1);
      core_reset_clear = 1'b0;
      tick(3);
      chk(6'({core_reset, periph_pci_access_en}), 6'h0);
      chk(6'(n_init - n0), 6'(f));
    end
  endtask
  // one cycle gap before each request, so valid is never set twice in one step
  task automatic acc(input logic w, d, a, e, input logic [1:0] b);
    int i;
    tick(1);
    {req_valid, req_write, req_data, req_atomic, req_lock_end, req_beats} = {1'b1, w, d, a, e, b};
    slow = use_internal_mc ? 2'($urandom_range(2)) : 2'h0;
    for (i = 0; i < 40 && req_ready !== 1'b1; i++) tick(1);
    chk(6'(i < 40), 6'h1);
    if (i == 40) wrap_up();
    q.push_back({w, d, w});
    tick(1);
    req_valid = 1'b0;
  endtask
  always @(negedge mclk)
    if (xfer_done === 1'b1)
      chk(6'({write_read_flag, data_code_flag_o, xfer_direction, data_phase_enable_n}), 6'({q.pop_front(), 1'b0}));
  initial begin
    int i;
    void'($urandom(32'hF1075067));
    tick(12);
    rst = 1'b0;
    boot(1'b0, 1'b1, 1'b0, 1'b1);
    boot(1'b0, 1'b1, 1'b1, 1'b0);
    boot(1'b1, 1'b1, 1'b1, 1'b1);
    repeat (12) acc(1'($urandom), 1'($urandom), 1'b0, 1'b0, 2'($urandom));
    tick(8);
    use_internal_mc = 1'b0;
    repeat (4) acc(1'($urandom), 1'($urandom), 1'b0, 1'b0, 2'($urandom));
    tick(8);
    use_internal_mc = 1'b1;
    acc(1'b0, 1'b1, 1'b1, 1'b0, 2'h0);
    want_bus = 1'b1;
    // idle with no request pending: only the lock can hold the grant back
    tick(8);
    chk(6'(bus_grant_ack), 6'h0);
    acc(1'b1, 1'b1, 1'b1, 1'b1, 2'h1);
    for (i = 0; i < 30 && bus_grant_ack !== 1'b1; i++) tick(1);
    chk(6'({bus_grant_ack, req_ready, data_code_flag_oe, atomic_lock_oe}), 6'h8);
    want_bus = 1'b0;
    tick(8);
    chk(6'(bus_grant_ack), 6'h0);
    boot(1'b1, 1'b0, 1'b0, 1'b1);
    chk(6'({req_ready, data_code_flag_oe, atomic_lock_oe, local_ready_recover_oe}), 6'h0);
    chk(6'(q.size()), 6'h0);
    wrap_up();
  end
endmodule // lbcs_ctrl_bench
bind lbcs_ctrl lbcs_checker chk_u (.*);
